// ### verilog/wdpd_ctrl.sv
// Watchdog timer and power-down control with Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
module wdpd_ctrl #(
	parameter int WDT_OSC_CYCLES    = wdpd_pkg::WDT_OSC_PERIOD_NS / wdpd_pkg::CLK_PERIOD_NS,
	parameter int WDT_TIMEOUT_TICKS = wdpd_pkg::WDT_TIMEOUT_TICKS,
	parameter int PORTA_W           = wdpd_pkg::PORTA_W,
	parameter int NUM_IRQ           = wdpd_pkg::NUM_IRQ
) (
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        resetn,
	// Avalon-MM slave
	input  wire logic [wdpd_pkg::ADDR_W-1:0] avs_address,
	input  wire logic                        avs_read,
	input  wire logic                        avs_write,
	input  wire logic [31:0]                 avs_writedata,
	input  wire logic [3:0]                  avs_byteenable,
	output logic      [31:0]                 avs_readdata,
	output logic                             avs_waitrequest,
	// Wake sources
	input  wire logic                        external_reset_pin_n,
	input  wire logic [PORTA_W-1:0]          porta_in,
	input  wire logic [NUM_IRQ-1:0]          irq_request,
	input  wire logic [NUM_IRQ-1:0]          irq_enable,
	input  wire logic                        irq_master_en,
	input  wire logic                        stack_full,
	// Core control
	output logic                             sys_osc_run,
	output logic                             osc_input_ignore,
	output logic                             state_retain,
	output logic                             chip_reset,
	output logic                             warm_reset,
	output logic                             resume_next,
	output logic                             irq_service,
	output logic                             timeout_flag,
	output logic                             powerdown_flag
);
	localparam int CW = $clog2(WDT_TIMEOUT_TICKS) + 1;
	localparam int DW = $clog2(wdpd_pkg::WAKE_DELAY_CYCLES) + 1;
	localparam int IW = $clog2(wdpd_pkg::INSTR_CLK_DIV);

	typedef struct packed {
		wdpd_pkg::wdpd_state_t state;
		wdpd_pkg::wdpd_cause_t cause;
		logic [CW-1:0]         count;
		logic [IW-1:0]         iclk_div;
		logic [DW-1:0]         delay;
		logic                  first_seen;
		logic                  timeout_flag;
		logic                  powerdown_flag;
		logic                  cfg_wdt_en;
		logic                  cfg_src_osc;
		logic                  cfg_osc_en;
		logic                  cfg_paired;
		logic [PORTA_W-1:0]    cfg_wake_mask;
		logic [PORTA_W-1:0]    porta_prev;
		logic [NUM_IRQ-1:0]    irq_stale;
		logic                  irq_go;
		logic                  irq_pend;
		logic                  ack;
		logic [31:0]           rdata;
		logic                  chip_reset;
		logic                  warm_reset;
		logic                  resume_next;
		logic                  irq_service;
	} wdpd_regs_t;

	wdpd_regs_t r_reg;
	wdpd_regs_t r_next;

	logic               osc_tick;
	logic               bus_req;
	logic               wr_acc;
	logic               cmd_ok;
	logic               clr_single;
	logic               clr_first;
	logic               clr_second;
	logic               halt_cmd;
	logic               iclk_tick;
	logic               wdt_tick;
	logic               wdt_clear;
	logic               ovf;
	logic [PORTA_W-1:0] port_fall;
	logic [NUM_IRQ-1:0] irq_new;

	wdpd_osc_tick #(
		.PERIOD (WDT_OSC_CYCLES)
	) u_osc (
		.clk    (clk),
		.resetn (resetn),
		.enable (r_reg.cfg_osc_en),
		.tick   (osc_tick)
	);

	function automatic logic [31:0] read_word(input logic [wdpd_pkg::ADDR_W-1:0] a,
		input wdpd_regs_t s);
		logic [31:0] w;
		w = '0;
		unique case (a)
			wdpd_pkg::REG_CTRL:
			begin
				w[wdpd_pkg::CTRL_WDT_EN] = s.cfg_wdt_en;
				w[wdpd_pkg::CTRL_SRC_OSC] = s.cfg_src_osc;
				w[wdpd_pkg::CTRL_OSC_EN] = s.cfg_osc_en;
				w[wdpd_pkg::CTRL_PAIRED] = s.cfg_paired;
				w[wdpd_pkg::CTRL_MASK_LSB +: PORTA_W] = s.cfg_wake_mask;
			end
			wdpd_pkg::REG_STATUS:
			begin
				w[wdpd_pkg::ST_TIMEOUT] = s.timeout_flag;
				w[wdpd_pkg::ST_PDOWN] = s.powerdown_flag;
				w[wdpd_pkg::ST_HALTED] = (s.state == wdpd_pkg::WDPD_HALT);
				w[wdpd_pkg::ST_WAKING] = (s.state == wdpd_pkg::WDPD_WAKE);
				w[wdpd_pkg::ST_FIRST] = s.first_seen;
				w[wdpd_pkg::ST_CAUSE_LSB +: 3] = s.cause;
			end
			wdpd_pkg::REG_COUNT:
				w[CW-1:0] = s.count;
			default:
				w = '0;
		endcase
		return w;
	endfunction : read_word

	// Bus handshake: one wait cycle per access
	assign bus_req = avs_read | avs_write;
	assign wr_acc = avs_write & r_reg.ack;
	assign cmd_ok = wr_acc && (avs_address == wdpd_pkg::REG_CMD) && avs_byteenable[0]
		&& (r_reg.state == wdpd_pkg::WDPD_RUN);

	// Clear commands gated by enable and clear mode
	assign clr_single = cmd_ok & avs_writedata[wdpd_pkg::CMD_CLR_SINGLE]
		& r_reg.cfg_wdt_en & ~r_reg.cfg_paired;
	assign clr_first = cmd_ok & avs_writedata[wdpd_pkg::CMD_CLR_FIRST]
		& r_reg.cfg_wdt_en & r_reg.cfg_paired;
	assign clr_second = cmd_ok & avs_writedata[wdpd_pkg::CMD_CLR_SECOND]
		& r_reg.cfg_wdt_en & r_reg.cfg_paired;
	assign halt_cmd = cmd_ok & avs_writedata[wdpd_pkg::CMD_HALT];

	// Instruction clock exists only while the core runs
	assign iclk_tick = (r_reg.state == wdpd_pkg::WDPD_RUN)
		&& (r_reg.iclk_div == IW'(wdpd_pkg::INSTR_CLK_DIV - 1));
	assign wdt_tick = r_reg.cfg_src_osc ? osc_tick : iclk_tick;
	assign wdt_clear = ~external_reset_pin_n | clr_single | (clr_second & r_reg.first_seen)
		| halt_cmd | ~r_reg.cfg_wdt_en;
	assign ovf = r_reg.cfg_wdt_en & wdt_tick & ~wdt_clear
		& (r_reg.count == CW'(WDT_TIMEOUT_TICKS - 1));

	assign port_fall = r_reg.porta_prev & ~porta_in & r_reg.cfg_wake_mask;
	assign irq_new = irq_request & ~r_reg.irq_stale;

	always_comb
	begin
		r_next = r_reg;
		r_next.chip_reset = 1'b0;
		r_next.warm_reset = 1'b0;
		r_next.resume_next = 1'b0;
		r_next.irq_service = 1'b0;
		r_next.porta_prev = porta_in;
		r_next.ack = bus_req & ~r_reg.ack;
		if (bus_req && !r_reg.ack)
			r_next.rdata = read_word(avs_address, r_reg);

		// Control register with byte lanes
		if (wr_acc && avs_address == wdpd_pkg::REG_CTRL)
		begin
			if (avs_byteenable[0])
			begin
				r_next.cfg_wdt_en = avs_writedata[wdpd_pkg::CTRL_WDT_EN];
				r_next.cfg_src_osc = avs_writedata[wdpd_pkg::CTRL_SRC_OSC];
				r_next.cfg_osc_en = avs_writedata[wdpd_pkg::CTRL_OSC_EN];
				r_next.cfg_paired = avs_writedata[wdpd_pkg::CTRL_PAIRED];
			end
			if (avs_byteenable[1])
				r_next.cfg_wake_mask = avs_writedata[wdpd_pkg::CTRL_MASK_LSB +: PORTA_W];
		end

		// Instruction clock divider frozen outside run
		if (r_reg.state == wdpd_pkg::WDPD_RUN)
			r_next.iclk_div = iclk_tick ? '0 : r_reg.iclk_div + IW'(1);

		// Watchdog count
		if (wdt_clear || ovf)
			r_next.count = '0;
		else if (wdt_tick)
			r_next.count = r_reg.count + CW'(1);

		// Paired clear progress
		if (!external_reset_pin_n || !r_reg.cfg_wdt_en || ovf || halt_cmd)
			r_next.first_seen = 1'b0;
		else if (clr_first)
			r_next.first_seen = 1'b1;
		else if (clr_second)
			r_next.first_seen = 1'b0;

		// Flags: setting wins over clearing
		if (clr_single)
		begin
			r_next.timeout_flag = 1'b0;
			r_next.powerdown_flag = 1'b0;
		end
		if (halt_cmd)
		begin
			r_next.powerdown_flag = 1'b1;
			r_next.timeout_flag = 1'b0;
		end
		if (ovf)
			r_next.timeout_flag = 1'b1;

		if (ovf && r_reg.state != wdpd_pkg::WDPD_HALT)
			r_next.chip_reset = 1'b1;

		// Deferred service entry after the wake delay
		if (r_reg.irq_pend)
		begin
			r_next.irq_pend = 1'b0;
			r_next.irq_service = 1'b1;
		end

		unique case (r_reg.state)
			wdpd_pkg::WDPD_RUN:
			begin
				if (halt_cmd)
				begin
					r_next.state = wdpd_pkg::WDPD_HALT;
					r_next.irq_stale = irq_request;
					r_next.cause = wdpd_pkg::WDPD_CAUSE_NONE;
				end
			end
			wdpd_pkg::WDPD_HALT:
			begin
				r_next.delay = '0;
				if (!external_reset_pin_n)
				begin
					r_next.state = wdpd_pkg::WDPD_WAKE;
					r_next.cause = wdpd_pkg::WDPD_CAUSE_RESET;
				end
				else if (ovf)
				begin
					r_next.state = wdpd_pkg::WDPD_WAKE;
					r_next.cause = wdpd_pkg::WDPD_CAUSE_WDT;
					r_next.warm_reset = 1'b1;
				end
				else if (|irq_new)
				begin
					r_next.state = wdpd_pkg::WDPD_WAKE;
					r_next.cause = wdpd_pkg::WDPD_CAUSE_IRQ;
					r_next.irq_go = (|(irq_new & irq_enable)) & irq_master_en
						& ~stack_full;
				end
				else if (|port_fall)
				begin
					r_next.state = wdpd_pkg::WDPD_WAKE;
					r_next.cause = wdpd_pkg::WDPD_CAUSE_PORT;
				end
			end
			wdpd_pkg::WDPD_WAKE:
			begin
				r_next.delay = r_reg.delay + DW'(1);
				if (r_reg.delay == DW'(wdpd_pkg::WAKE_DELAY_CYCLES - 1))
				begin
					r_next.state = wdpd_pkg::WDPD_RUN;
					if (r_reg.cause == wdpd_pkg::WDPD_CAUSE_IRQ && r_reg.irq_go)
						r_next.irq_pend = 1'b1;
					else if (r_reg.cause == wdpd_pkg::WDPD_CAUSE_IRQ
						|| r_reg.cause == wdpd_pkg::WDPD_CAUSE_PORT)
						r_next.resume_next = 1'b1;
				end
			end
			default:
				r_next.state = wdpd_pkg::WDPD_RUN;
		endcase
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			r_reg <= '0;
			r_reg.cfg_wdt_en <= wdpd_pkg::CTRL_RESET[wdpd_pkg::CTRL_WDT_EN];
			r_reg.cfg_src_osc <= wdpd_pkg::CTRL_RESET[wdpd_pkg::CTRL_SRC_OSC];
			r_reg.cfg_osc_en <= wdpd_pkg::CTRL_RESET[wdpd_pkg::CTRL_OSC_EN];
			r_reg.cfg_paired <= wdpd_pkg::CTRL_RESET[wdpd_pkg::CTRL_PAIRED];
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	assign avs_readdata = r_reg.rdata;
	assign avs_waitrequest = bus_req & ~r_reg.ack;
	assign sys_osc_run = (r_reg.state != wdpd_pkg::WDPD_HALT);
	assign osc_input_ignore = (r_reg.state == wdpd_pkg::WDPD_HALT);
	assign state_retain = (r_reg.state == wdpd_pkg::WDPD_HALT);
	assign chip_reset = r_reg.chip_reset;
	assign warm_reset = r_reg.warm_reset;
	assign resume_next = r_reg.resume_next;
	assign irq_service = r_reg.irq_service;
	assign timeout_flag = r_reg.timeout_flag;
	assign powerdown_flag = r_reg.powerdown_flag;

	// Helper: cycles spent in the wake delay
	localparam int WAKE_LEN = wdpd_pkg::WAKE_DELAY_CYCLES;
	logic [DW:0] wake_len_reg;
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			wake_len_reg <= '0;
		else if (r_reg.state == wdpd_pkg::WDPD_WAKE)
			wake_len_reg <= wake_len_reg + (DW+1)'(1);
		else if (!r_reg.resume_next && !r_reg.irq_pend)
			wake_len_reg <= '0;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_halt_osc_stop: assert property (
		r_reg.state == wdpd_pkg::WDPD_HALT |-> !sys_osc_run && osc_input_ignore)
		else $error("oscillator runs in power-down");
	a_halt_flags: assert property (
		halt_cmd |=> powerdown_flag && !timeout_flag && r_reg.count == '0
		&& r_reg.state == wdpd_pkg::WDPD_HALT)
		else $error("halt did not set flags or clear count");
	a_disabled_zero: assert property (
		!r_reg.cfg_wdt_en |=> r_reg.count == '0 && !$rose(timeout_flag))
		else $error("disabled watchdog counted");
	a_instr_frozen: assert property (
		r_reg.state == wdpd_pkg::WDPD_HALT && !r_reg.cfg_src_osc
		&& external_reset_pin_n && r_reg.cfg_wdt_en |=> $stable(r_reg.count))
		else $error("instruction clock count moved in power-down");
	a_single_clear: assert property (
		clr_single |=> r_reg.count == '0 && !powerdown_flag && !timeout_flag)
		else $error("single clear failed");
	a_paired_first: assert property (
		clr_first && !halt_cmd && !ovf && external_reset_pin_n |=> r_reg.first_seen)
		else $error("first clear not remembered");
	a_paired_only: assert property (
		clr_second && !r_reg.first_seen && !clr_single && !halt_cmd && external_reset_pin_n
		&& r_reg.cfg_wdt_en && !wdt_tick |=> $stable(r_reg.count))
		else $error("second clear alone cleared count");
	a_run_ovf_reset: assert property (
		chip_reset |-> timeout_flag && $past(r_reg.state) != wdpd_pkg::WDPD_HALT)
		else $error("chip reset without timeout");
	a_warm_reset: assert property (
		warm_reset |-> timeout_flag && r_reg.state == wdpd_pkg::WDPD_WAKE
		&& r_reg.cause == wdpd_pkg::WDPD_CAUSE_WDT)
		else $error("warm reset out of power-down");
	a_wake_length: assert property (
		resume_next |-> wake_len_reg == (DW+1)'(WAKE_LEN))
		else $error("wake delay not 1024 cycles");
	a_irq_late: assert property (
		$fell(r_reg.state == wdpd_pkg::WDPD_WAKE) && r_reg.irq_pend |-> ##1 irq_service)
		else $error("service entry not one cycle late");
	a_bus_answer: assert property (
		bus_req && avs_waitrequest |=> bus_req |-> !avs_waitrequest)
		else $error("bus answer missing");

	c_halt_entry: cover property (halt_cmd);
	c_port_wake: cover property (resume_next && r_reg.cause == wdpd_pkg::WDPD_CAUSE_PORT);
	c_irq_serve: cover property (irq_service);
	c_warm: cover property (warm_reset);
endmodule : wdpd_ctrl
`default_nettype wire

// ### verilog/wdpd_pkg.sv
// Constants, types and register map of the watchdog and power-down control
package wdpd_pkg;
	localparam int CLK_PERIOD_NS      = 10;
	localparam int WDT_OSC_PERIOD_NS  = 65000;
	localparam int INSTR_CLK_DIV      = 4;
	localparam int WDT_TIMEOUT_TICKS  = 65536;
	localparam int WAKE_DELAY_CYCLES  = 1024;
	localparam int PORTA_W            = 8;
	localparam int NUM_IRQ            = 4;
	localparam int ADDR_W             = 4;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
	localparam logic [ADDR_W-1:0] REG_CMD    = 4'h4;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h8;
	localparam logic [ADDR_W-1:0] REG_COUNT  = 4'hC;

	// Control fields
	localparam int CTRL_WDT_EN   = 0;
	localparam int CTRL_SRC_OSC  = 1;
	localparam int CTRL_OSC_EN   = 2;
	localparam int CTRL_PAIRED   = 3;
	localparam int CTRL_MASK_LSB = 8;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0007;

	// Command fields
	localparam int CMD_CLR_SINGLE = 0;
	localparam int CMD_CLR_FIRST  = 1;
	localparam int CMD_CLR_SECOND = 2;
	localparam int CMD_HALT       = 3;

	// Status fields
	localparam int ST_TIMEOUT   = 0;
	localparam int ST_PDOWN     = 1;
	localparam int ST_HALTED    = 2;
	localparam int ST_WAKING    = 3;
	localparam int ST_FIRST     = 4;
	localparam int ST_CAUSE_LSB = 8;

	typedef enum logic [1:0] {WDPD_RUN, WDPD_HALT, WDPD_WAKE} wdpd_state_t;
	typedef enum logic [2:0] {
		WDPD_CAUSE_NONE,
		WDPD_CAUSE_RESET,
		WDPD_CAUSE_IRQ,
		WDPD_CAUSE_PORT,
		WDPD_CAUSE_WDT
	} wdpd_cause_t;
endpackage : wdpd_pkg

// ### verilog/wdpd_osc_tick.sv
// Free-running watchdog oscillator model as a periodic tick
`timescale 1ns/1ps
`default_nettype none
module wdpd_osc_tick #(
	parameter int PERIOD = 6500
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// Control and tick
	input  wire logic enable,
	output logic      tick
);
	localparam int PW = $clog2(PERIOD) + 1;

	typedef struct packed {
		logic [PW-1:0] cnt;
		logic          tick;
	} wdpd_tick_t;

	wdpd_tick_t r_reg;
	wdpd_tick_t r_next;

	always_comb
	begin
		r_next = r_reg;
		r_next.tick = 1'b0;
		if (!enable)
		begin
			r_next.cnt = '0;
		end
		else if (r_reg.cnt == PW'(PERIOD - 1))
		begin
			r_next.cnt = '0;
			r_next.tick = 1'b1;
		end
		else
		begin
			r_next.cnt = r_reg.cnt + PW'(1);
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end

	assign tick = r_reg.tick;
endmodule : wdpd_osc_tick
`default_nettype wire

// ### tb/wdpd_far_model.sv
// Far-side model: external reset pin and port A wake lines
`timescale 1ns/1ps
`default_nettype none
module wdpd_far_model #(
	parameter int PORTA_W = 8
) (
	// Clock
	input  wire logic               clk,
	// Pins toward the block
	output logic                    external_reset_pin_n,
	output logic [PORTA_W-1:0]      porta_in
);
	// Port lines idle high through their pull-ups
	initial
	begin
		external_reset_pin_n = 1'h1;
		porta_in             = '1;
	end

	task automatic port_fall(input int b);
		@(posedge clk);
		porta_in[b] <= 1'h0;
	endtask : port_fall

	task automatic port_idle();
		@(posedge clk);
		porta_in <= '1;
	endtask : port_idle

	// Pin held low a few cycles, then released
	task automatic pin_reset();
		@(posedge clk);
		external_reset_pin_n <= 1'h0;
		repeat (4) @(posedge clk);
		external_reset_pin_n <= 1'h1;
	endtask : pin_reset
endmodule : wdpd_far_model
`default_nettype wire

// ### tb/wdpd_ctrl_tb.sv
// Self-checking bench for the watchdog and power-down control
`timescale 1ns/1ps
`default_nettype none
module wdpd_ctrl_tb;
	localparam int OSC = 8;
	localparam int TKS = 16;
	typedef struct packed {
		logic [31:0] ctrl;
		logic [3:0]  c1;
		logic [3:0]  c2;
		logic        trip;
	} wdpd_row_t;
	logic        clk = 1'h0;
	logic        resetn = 1'h0;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'h0;
	logic        avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	wire logic   rst_pin_n;
	wire logic [7:0] porta;
	logic [3:0]  irq_req = 4'h0;
	logic [3:0]  irq_en = 4'h1;
	logic        irq_m = 1'h1;
	logic        stk_full = 1'h0;
	logic        osc_run, in_ign, retain, chip_rst, warm_rst, resume, service, to_f, pd_f;
	logic [31:0] r;
	int          err_total = 0;
	int          n_compared = 0;
	int          cyc = 0;
	int          n;
	int          b;
	int          cnt[4] = '{0, 0, 0, 0};
	wdpd_row_t   rows[6] = '{
		'{32'h7, 4'h1, 4'h0, 1'h0},
		'{32'hF, 4'h1, 4'h0, 1'h1},
		'{32'hF, 4'h4, 4'h0, 1'h1},
		'{32'hF, 4'h2, 4'h0, 1'h1},
		'{32'hF, 4'h2, 4'h4, 1'h0},
		'{32'h7, 4'h2, 4'h4, 1'h1}};

	wdpd_ctrl #(.WDT_OSC_CYCLES(OSC), .WDT_TIMEOUT_TICKS(TKS)) DUT (
		.clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.external_reset_pin_n(rst_pin_n), .porta_in(porta), .irq_request(irq_req),
		.irq_enable(irq_en), .irq_master_en(irq_m), .stack_full(stk_full),
		.sys_osc_run(osc_run), .osc_input_ignore(in_ign), .state_retain(retain),
		.chip_reset(chip_rst), .warm_reset(warm_rst), .resume_next(resume),
		.irq_service(service), .timeout_flag(to_f), .powerdown_flag(pd_f));

	wdpd_far_model #(.PORTA_W(8)) far (
		.clk(clk), .external_reset_pin_n(rst_pin_n), .porta_in(porta));

	always #5 clk = ~clk;

	always @(posedge clk)
	begin
		cyc++;
		if (chip_rst === 1'h1) cnt[0]++;
		if (warm_rst === 1'h1) cnt[1]++;
		if (resume === 1'h1) cnt[2]++;
		if (service === 1'h1) cnt[3]++;
		if (cyc == 20000)
		begin
			err_total++;
			print_verdict();
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e)
		begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic rng(input int g, input int lo, input int hi);
		n_compared++;
		if (g < lo || g > hi)
		begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
		end
	endtask : rng

	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= w;
		avs_read      <= ~w;
		// Answer taken at the edge that sees waitrequest low
		@(posedge clk);
		while (avs_waitrequest !== 1'h0)
			@(posedge clk);
		r = avs_readdata;
		avs_write <= 1'h0;
		avs_read  <= 1'h0;
	endtask : bus

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		bus(1'h1, a, d);
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		bus(1'h0, a, 32'h0);
		chk(r, e);
	endtask : rd

	// Counts cycles until the chosen pulse counter moves, up to lim
	task automatic wait_ev(input int s, input int lim);
		int b0;
		@(negedge clk);
		b0 = cnt[s];
		n = 0;
		while (cnt[s] == b0 && n < lim)
		begin
			@(negedge clk);
			n++;
		end
	endtask : wait_ev

	task automatic irq_wake(input logic sf, input int s);
		wr(4'h4, 32'h1);
		stk_full <= sf;
		wr(4'h4, 32'h8);
		@(posedge clk);
		irq_req <= 4'h1;
		wait_ev(s, 1200);
		rng(n, 1020, 1034);
		@(posedge clk);
		irq_req <= 4'h0;
	endtask : irq_wake

	task automatic print_verdict();
		$display("compared=%0d errors=%0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict

	initial
	begin
		repeat (10) @(posedge clk);
		resetn <= 1'h1;
		@(negedge clk);
		chk(32'({osc_run, in_ign, retain, to_f, pd_f}), 32'h10);
		rd(4'h0, 32'h7);
		wr(4'h8, 32'hF);
		rd(4'h8, 32'h0);
		rd(4'h2, 32'h0);
		wr(4'h0, 32'h107);
		rd(4'h0, 32'h107);
		wr(4'h0, 32'h7);
		wr(4'h4, 32'h1);
		wait_ev(0, 300);
		rng(n, 118, 140);
		chk(32'(to_f), 32'h1);
		wr(4'h0, 32'h1);
		wr(4'h4, 32'h1);
		wait_ev(0, 200);
		rng(n, 58, 72);
		// Disabled watchdog: clear has no effect, count parked at zero
		wr(4'h0, 32'h6);
		wr(4'h4, 32'h1);
		wait_ev(0, 300);
		rng(n, 300, 300);
		chk(32'(to_f), 32'h1);
		rd(4'hC, 32'h0);
		wr(4'h0, 32'h3);
		wr(4'h4, 32'h1);
		wait_ev(0, 300);
		rng(n, 300, 300);
		foreach (rows[i])
		begin
			wr(4'h0, rows[i].ctrl);
			@(negedge clk);
			b = cnt[0];
			repeat (7)
			begin
				if (rows[i].c1 !== 4'h0) wr(4'h4, 32'(rows[i].c1));
				if (rows[i].c2 !== 4'h0) wr(4'h4, 32'(rows[i].c2));
				repeat (55) @(posedge clk);
			end
			@(negedge clk);
			chk(32'(cnt[0] != b), 32'(rows[i].trip));
		end
		// Halt with instruction-clock source, wake by port A bit 0
		wr(4'h0, 32'h101);
		wait_ev(0, 100);
		wr(4'h4, 32'h8);
		@(negedge clk);
		chk(32'({osc_run, in_ign, retain, to_f, pd_f}), 32'hD);
		b = cnt[0];
		wait_ev(1, 200);
		rng(n + cnt[0] - b, 200, 200);
		far.port_fall(1);
		repeat (30) @(negedge clk);
		chk(32'(osc_run), 32'h0);
		far.port_fall(0);
		wait_ev(2, 1200);
		rng(n, 1020, 1032);
		far.port_idle();
		chk(32'({osc_run, pd_f}), 32'h3);
		wr(4'h4, 32'h1);
		@(negedge clk);
		chk(32'(pd_f), 32'h0);
		wr(4'h0, 32'h1);
		irq_wake(1'h0, 3);
		irq_wake(1'h1, 2);
		// Request already pending at halt entry must not wake
		@(posedge clk);
		irq_req <= 4'h1;
		wr(4'h4, 32'h1);
		wr(4'h4, 32'h8);
		repeat (100) @(negedge clk);
		chk(32'(osc_run), 32'h0);
		b = cnt[2] + cnt[3];
		far.pin_reset();
		// Waking, cause reset pin, powerdown flag kept
		rd(4'h8, 32'h10A);
		repeat (1030) @(negedge clk);
		rd(4'h8, 32'h102);
		chk(32'(cnt[2] + cnt[3]), 32'(b));
		irq_req <= 4'h0;
		wr(4'h0, 32'h7);
		wr(4'h4, 32'h8);
		wait_ev(1, 300);
		rng(n, 118, 142);
		chk(32'({to_f, pd_f}), 32'h3);
		repeat (1100) @(posedge clk);
		print_verdict();
	end
endmodule : wdpd_ctrl_tb
`default_nettype wire
